// >>> rtl/nct_consts.svh
// offsets, field positions, reset values and counts of the countdown timer
// assumes byte-wide registers on a plain strobe port
`ifndef NCT_CONSTS_SVH
`define NCT_CONSTS_SVH

`define NCT_ADDR_W          8
`define NCT_DATA_W          8
`define NCT_CNT_W           16

`define NCT_OFS_CONTROL     8'h19
`define NCT_OFS_RELOAD_HI   8'h1a
`define NCT_OFS_RELOAD_LO   8'h1b
`define NCT_OFS_COUNT_HI    8'h1c
`define NCT_OFS_COUNT_LO    8'h1d
`define NCT_OFS_IRQ_STATUS  8'h30
`define NCT_OFS_IRQ_CLEAR   8'h31
`define NCT_OFS_IRQ_ENABLE  8'h32
`define NCT_OFS_COMMAND     8'h33

`define NCT_CTRL_WR_MASK    8'hbb
`define NCT_CTRL_RESET      8'h00
`define NCT_RELOAD_RESET    16'h0000
`define NCT_COUNT_RESET     16'h0000
`define NCT_IRQ_RESET       3'h0

`define NCT_IRQ_W           3
`define NCT_IRQ_UNDERFLOW   0
`define NCT_IRQ_RX_STOP     1
`define NCT_IRQ_START       2

`define NCT_CMD_START       0
`define NCT_CMD_STOP        1
`define NCT_STAT_RUNNING    0

`define NCT_DIV_212K        64

`endif

// >>> rtl/nct_pkg.sv
// types shared by the countdown timer files
// assumes nothing beyond the constants header
package nct_pkg;

   typedef enum logic [1:0] {
      NCT_START_NONE,
      NCT_START_TX_END,
      NCT_START_TRIM_NO_UF,
      NCT_START_TRIM_UF
   } nct_start_t;

   typedef enum logic [1:0] {
      NCT_CLK_CARRIER,
      NCT_CLK_DIV212K,
      NCT_CLK_SIB0_UF,
      NCT_CLK_SIB1_UF
   } nct_clk_t;

   typedef struct packed {
      logic       stop_on_receive;
      logic       rsv6;
      nct_start_t start_source_select;
      logic       auto_reload_enable;
      logic       rsv2;
      nct_clk_t   count_clock_select;
   } nct_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } nct_bus_req_t;

   typedef enum logic [0:0] {
      NCT_ST_IDLE,
      NCT_ST_RUN
   } nct_state_t;

endpackage : nct_pkg

// >>> rtl/nct_tick_gen.sv
// count clock selection of the countdown timer
// assumes carrier and sibling underflow strobes are one-cycle pulses on clock
`timescale 1ns/100ps
`include "nct_consts.svh"

module nct_tick_gen #(
   parameter int DIV = `NCT_DIV_212K
) (
   input  wire logic              clock,        // system clock
   input  wire logic              resetn,       // synchronous reset, low
   input  wire nct_pkg::nct_clk_t clk_sel,      // count clock source
   input  wire logic              carrier_tick, // one pulse per carrier period
   input  wire logic              sib0_uf,      // first sibling underflow pulse
   input  wire logic              sib1_uf,      // second sibling underflow pulse
   output logic                   tick          // one decrement strobe
);

   localparam int DW = $clog2(DIV);

   logic [DW-1:0] div_r;
   logic          div_tick;

   // carrier divider for the slow count clock
   always_ff @(posedge clock) begin
      if (!resetn) begin
         div_r <= '0;
      end else if (carrier_tick) begin
         div_r <= (div_r == DW'(DIV - 1)) ? '0 : div_r + 1'b1;
      end
   end

   assign div_tick = carrier_tick && (div_r == DW'(DIV - 1));

   // source mux
   always_comb begin
      case (clk_sel)
         nct_pkg::NCT_CLK_CARRIER: tick = carrier_tick;
         nct_pkg::NCT_CLK_DIV212K: tick = div_tick;
         nct_pkg::NCT_CLK_SIB0_UF: tick = sib0_uf;
         nct_pkg::NCT_CLK_SIB1_UF: tick = sib1_uf;
         default:                  tick = 1'b0;
      endcase
   end

endmodule : nct_tick_gen

// >>> rtl/nct_timer.sv
// one 16-bit countdown timer with control, reload, live count and interrupt
// assumes all inputs synchronous to clock, event inputs one-cycle pulses
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "nct_consts.svh"

module nct_timer #(
   parameter int DIV_212K = `NCT_DIV_212K
) (
   input  wire logic        clock,           // 10 MHz system clock
   input  wire logic        resetn,          // synchronous reset, low
   input  wire logic [7:0]  addr,            // register address
   input  wire logic [7:0]  wr_data,         // register write data
   input  wire logic        wr_en,           // write strobe
   input  wire logic        rd_en,           // read strobe
   output logic      [7:0]  rd_data,         // read data, cycle after strobe
   input  wire logic        carrier_tick,    // carrier period pulse
   input  wire logic        tx_done,         // transmission finished pulse
   input  wire logic        rx_first_bits,   // first four bits received pulse
   input  wire logic        low_freq_osc,    // oscillator level under trim
   input  wire logic        sib0_underflow,  // first sibling timer underflow
   input  wire logic        sib1_underflow,  // second sibling timer underflow
   output logic             timer_underflow, // underflow pulse
   output logic             timer_running,   // timer counting
   output logic             timer_irq        // level interrupt
);

   // decode helpers
   function automatic logic f_is_trim(input nct_pkg::nct_start_t s);
      f_is_trim = (s == nct_pkg::NCT_START_TRIM_NO_UF) ||
                  (s == nct_pkg::NCT_START_TRIM_UF);
   endfunction : f_is_trim

   function automatic logic f_hit(input logic [7:0] a, input logic [7:0] ofs);
      f_hit = (a == ofs);
   endfunction : f_hit

   nct_pkg::nct_bus_req_t req;
   nct_pkg::nct_ctrl_t    ctrl_r;
   nct_pkg::nct_state_t   state_r;
   nct_pkg::nct_state_t   state_nxt;

   logic [7:0]                  reload_hi_r;
   logic [7:0]                  reload_lo_r;
   logic [`NCT_CNT_W-1:0]       count_r;
   logic [`NCT_CNT_W-1:0]       count_nxt;
   logic [`NCT_IRQ_W-1:0]       irq_status_r;
   logic [`NCT_IRQ_W-1:0]       irq_enable_r;
   logic [`NCT_IRQ_W-1:0]       irq_event;
   logic [`NCT_IRQ_W-1:0]       irq_clear;
   logic                        uf_r;
   logic                        uf_nxt;
   logic                        lfo_d_r;
   logic                        lfo_rise;
   logic                        tick;
   logic                        trim;
   logic                        running;
   logic                        sw_start;
   logic                        sw_stop;
   logic                        auto_start;
   logic                        rx_stop;
   logic                        trim_toggle;
   logic                        start_evt;
   logic                        stop_evt;
   logic                        at_zero;
   logic                        uf_allowed;
   logic [7:0]                  rd_nxt;

   // bundle the bus port
   assign req.addr  = addr;
   assign req.wdata = wr_data;
   assign req.wr    = wr_en;
   assign req.rd    = rd_en;

   // count clock source
   nct_tick_gen #(
      .DIV (DIV_212K)
   ) u_tick (
      .clock        (clock),
      .resetn       (resetn),
      .clk_sel      (ctrl_r.count_clock_select),
      .carrier_tick (carrier_tick),
      .sib0_uf      (sib0_underflow),
      .sib1_uf      (sib1_underflow),
      .tick         (tick)
   );

   // control register, reserved bits forced low
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctrl_r <= nct_pkg::nct_ctrl_t'(`NCT_CTRL_RESET);
      end else if (req.wr && f_hit(req.addr, `NCT_OFS_CONTROL)) begin
         ctrl_r <= nct_pkg::nct_ctrl_t'(req.wdata & `NCT_CTRL_WR_MASK);
      end
   end

   // reload bytes, only stored here, used at the next start or auto reload
   always_ff @(posedge clock) begin
      if (!resetn) begin
         reload_hi_r <= 8'(`NCT_RELOAD_RESET >> 8);
         reload_lo_r <= 8'(`NCT_RELOAD_RESET & 16'h00ff);
      end else if (req.wr) begin
         if (f_hit(req.addr, `NCT_OFS_RELOAD_HI)) begin
            reload_hi_r <= req.wdata;
         end
         if (f_hit(req.addr, `NCT_OFS_RELOAD_LO)) begin
            reload_lo_r <= req.wdata;
         end
      end
   end

   // interrupt enable register
   always_ff @(posedge clock) begin
      if (!resetn) begin
         irq_enable_r <= `NCT_IRQ_RESET;
      end else if (req.wr && f_hit(req.addr, `NCT_OFS_IRQ_ENABLE)) begin
         irq_enable_r <= req.wdata[`NCT_IRQ_W-1:0];
      end
   end

   // software command strobes
   assign sw_start = req.wr && f_hit(req.addr, `NCT_OFS_COMMAND) &&
                     req.wdata[`NCT_CMD_START];
   assign sw_stop  = req.wr && f_hit(req.addr, `NCT_OFS_COMMAND) &&
                     req.wdata[`NCT_CMD_STOP];

   // oscillator edge detector
   always_ff @(posedge clock) begin
      if (!resetn) begin
         lfo_d_r <= 1'b0;
      end else begin
         lfo_d_r <= low_freq_osc;
      end
   end

   assign lfo_rise = low_freq_osc && !lfo_d_r;

   // start and stop sources
   assign trim        = f_is_trim(ctrl_r.start_source_select);
   assign running     = (state_r == nct_pkg::NCT_ST_RUN);
   assign trim_toggle = trim && lfo_rise;
   assign auto_start  = (ctrl_r.start_source_select == nct_pkg::NCT_START_TX_END) &&
                        tx_done;
   assign rx_stop     = !trim && ctrl_r.stop_on_receive &&
                        rx_first_bits && running;
   assign start_evt   = sw_start || auto_start || (trim_toggle && !running);
   assign stop_evt    = sw_stop || rx_stop || (trim_toggle && running);
   assign at_zero     = (count_r == '0);
   assign uf_allowed  = (ctrl_r.start_source_select != nct_pkg::NCT_START_TRIM_NO_UF);

   // next count and state, stop has priority over start
   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      uf_nxt    = 1'b0;
      case (state_r)
         nct_pkg::NCT_ST_IDLE: begin
            if (!stop_evt && start_evt) begin
               state_nxt = nct_pkg::NCT_ST_RUN;
               count_nxt = {reload_hi_r, reload_lo_r};
            end
         end
         nct_pkg::NCT_ST_RUN: begin
            if (stop_evt) begin
               state_nxt = nct_pkg::NCT_ST_IDLE;
            end else if (start_evt) begin
               count_nxt = {reload_hi_r, reload_lo_r};
            end else if (tick) begin
               if (!at_zero) begin
                  count_nxt = count_r - 1'b1;
               end else if (uf_allowed) begin
                  uf_nxt = 1'b1;
                  if (ctrl_r.auto_reload_enable) begin
                     count_nxt = {reload_hi_r, reload_lo_r};
                  end else begin
                     state_nxt = nct_pkg::NCT_ST_IDLE;
                  end
               end
            end
         end
         default: begin
            state_nxt = nct_pkg::NCT_ST_IDLE;
         end
      endcase
   end

   // counter state
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_r <= nct_pkg::NCT_ST_IDLE;
         count_r <= `NCT_COUNT_RESET;
         uf_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         uf_r    <= uf_nxt;
      end
   end

   // interrupt sources and clear strobes
   always_comb begin
      irq_event = '0;
      irq_event[`NCT_IRQ_UNDERFLOW] = uf_nxt;
      irq_event[`NCT_IRQ_RX_STOP]   = rx_stop;
      irq_event[`NCT_IRQ_START]     = start_evt && !stop_evt;
      irq_clear = '0;
      if (req.wr && f_hit(req.addr, `NCT_OFS_IRQ_CLEAR)) begin
         irq_clear = req.wdata[`NCT_IRQ_W-1:0];
      end
   end

   // sticky status, a new event beats a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!resetn) begin
         irq_status_r <= `NCT_IRQ_RESET;
      end else begin
         irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
      end
   end

   // read mux
   always_comb begin
      rd_nxt = 8'h00;
      case (req.addr)
         `NCT_OFS_CONTROL:    rd_nxt = ctrl_r;
         `NCT_OFS_RELOAD_HI:  rd_nxt = reload_hi_r;
         `NCT_OFS_RELOAD_LO:  rd_nxt = reload_lo_r;
         `NCT_OFS_COUNT_HI:   rd_nxt = count_r[15:8];
         `NCT_OFS_COUNT_LO:   rd_nxt = count_r[7:0];
         `NCT_OFS_IRQ_STATUS: rd_nxt = {5'h00, irq_status_r};
         `NCT_OFS_IRQ_ENABLE: rd_nxt = {5'h00, irq_enable_r};
         `NCT_OFS_COMMAND:    rd_nxt = {7'h00, running};
         default:             rd_nxt = 8'h00;
      endcase
   end

   // read data register, valid only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else if (req.rd) begin
         rd_data <= rd_nxt;
      end else begin
         rd_data <= 8'h00;
      end
   end

   // outputs
   assign timer_underflow = uf_r;
   assign timer_running   = running;
   assign timer_irq       = |(irq_status_r & irq_enable_r);

endmodule : nct_timer

// >>> testbench/nct_timer_properties.sv
// concurrent checks on the countdown timer ports
// assumes the constants header map and one clock domain
`timescale 1ns/100ps
`include "nct_consts.svh"
module nct_timer_properties (
   input wire logic       clock,           // system clock
   input wire logic       resetn,          // synchronous reset, low
   input wire logic [7:0] addr,            // register address
   input wire logic [7:0] wr_data,         // write data
   input wire logic       wr_en,           // write strobe
   input wire logic       rd_en,           // read strobe
   input wire logic [7:0] rd_data,         // read data
   input wire logic       carrier_tick,    // carrier pulse
   input wire logic       tx_done,         // transmit end
   input wire logic       rx_first_bits,   // first bits received
   input wire logic       low_freq_osc,    // oscillator level
   input wire logic       sib0_underflow,  // sibling underflow
   input wire logic       sib1_underflow,  // sibling underflow
   input wire logic       timer_underflow, // underflow pulse
   input wire logic       timer_running,   // running level
   input wire logic       timer_irq        // interrupt level
);
   logic [7:0] ctl_r; // shadow of control
   logic       ien_r; // shadow of underflow enable
   logic       osc_r; // oscillator one cycle ago
   logic       cmd_wr;
   logic       osc_rise;
   assign cmd_wr   = wr_en && addr == `NCT_OFS_COMMAND;
   assign osc_rise = low_freq_osc && !osc_r;
   // shadows follow software writes
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctl_r <= 8'h00;
         ien_r <= 1'b0;
         osc_r <= 1'b0;
      end else begin
         osc_r <= low_freq_osc;
         if (wr_en && addr == `NCT_OFS_CONTROL)
            ctl_r <= wr_data & `NCT_CTRL_WR_MASK;
         if (wr_en && addr == `NCT_OFS_IRQ_ENABLE)
            ien_r <= wr_data[0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   a_read_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data not idle");
   a_src_none: assert property (ctl_r[5:4] == 2'b00 && !timer_running && !cmd_wr |=> !timer_running)
      else $error("timer started on its own");
   a_tx_start: assert property (ctl_r[5:4] == 2'b01 && tx_done && !rx_first_bits && !cmd_wr
      |=> timer_running)
      else $error("no start at transmit end");
   a_rx_stop: assert property (ctl_r[7] && !ctl_r[5] && rx_first_bits && timer_running
      |=> !timer_running)
      else $error("no stop on receive");
   a_trim_ignore: assert property (ctl_r[5:4] == 2'b10 && rx_first_bits && timer_running
      && !cmd_wr && !osc_rise |=> timer_running)
      else $error("trim stopped by receive");
   a_stop_zero: assert property (timer_underflow && !ctl_r[3] |-> !timer_running)
      else $error("still running after underflow");
   a_auto_reload: assert property (timer_underflow && ctl_r[3] |-> timer_running)
      else $error("stopped despite auto reload");
   a_irq_set: assert property (timer_underflow && ien_r |-> timer_irq)
      else $error("no interrupt on underflow");
endmodule : nct_timer_properties
bind nct_timer nct_timer_properties u_props (.clock, .resetn, .addr, .wr_data, .wr_en,
   .rd_en, .rd_data, .carrier_tick, .tx_done, .rx_first_bits, .low_freq_osc,
   .sib0_underflow, .sib1_underflow, .timer_underflow, .timer_running, .timer_irq);

// >>> testbench/nct_timer_tb.sv
// self-checking bench for the countdown timer against an integer model
// assumes the design register map and a divider shortened to 4
`timescale 1ns/100ps
module nct_timer_tb;
   logic       clock, resetn, wr_en, rd_en, carrier_tick, tx_done, rx_first_bits;
   logic       low_freq_osc, sib0_underflow, sib1_underflow;
   logic       timer_underflow, timer_running, timer_irq;
   logic [7:0] addr, wr_data, rd_data;
   int         errors, comparisons, m_cnt, m_rel, m_run, m_auto, m_hold, r;
   int         m_uf, uf_seen;
   logic [7:0] offs [7] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h30, 8'h7f};
   nct_timer #(.DIV_212K(4)) dut (.clock, .resetn, .addr, .wr_data, .wr_en, .rd_en,
      .rd_data, .carrier_tick, .tx_done, .rx_first_bits, .low_freq_osc, .sib0_underflow,
      .sib1_underflow, .timer_underflow, .timer_running, .timer_irq);
   // count underflow pulses seen on the output
   always @(posedge clock) begin
      if (timer_underflow === 1'b1)
         uf_seen++;
   end
   // clock of 100 ns
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task final_report;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      #1;
   endtask : wr
   task rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      check("register read", rd_data, e);
   endtask : rdc
   // hold one event input high for n cycles
   task pls(input int w, input int n);
      @(posedge clock);
      case (w)
         0: carrier_tick <= 1'b1;
         1: sib0_underflow <= 1'b1;
         2: sib1_underflow <= 1'b1;
         3: tx_done <= 1'b1;
         default: rx_first_bits <= 1'b1;
      endcase
      repeat (n) @(posedge clock);
      {carrier_tick, sib0_underflow, sib1_underflow, tx_done, rx_first_bits} <= 5'h00;
      #1;
   endtask : pls
   task osc_rise;
      @(posedge clock);
      low_freq_osc <= 1'b1;
      repeat (2) @(posedge clock);
      low_freq_osc <= 1'b0;
   endtask : osc_rise
   // model: n decrement ticks
   task step(input int n);
      repeat (n) begin
         if (m_run != 0 && m_cnt == 0 && m_hold == 0) begin
            m_run = m_auto;
            m_uf++;
            if (m_auto != 0)
               m_cnt = m_rel;
         end else if (m_run != 0 && m_cnt > 0)
            m_cnt--;
      end
   endtask : step
   // read the live count back and check the running flag against the model
   task st_chk;
      rdc(8'h1c, 8'(m_cnt >> 8));
      rdc(8'h1d, 8'(m_cnt));
      check("running", {7'h00, timer_running}, 8'(m_run));
   endtask : st_chk
   task go(input logic [7:0] c);
      wr(8'h19, c);
      m_auto = c[3];
      wr(8'h33, 8'h01);
      m_cnt = m_rel;
      m_run = 1;
   endtask : go
   // watchdog
   initial begin
      repeat (5000) @(posedge clock);
      errors++;
      final_report;
   end
   // main sequence
   initial begin
      {resetn, wr_en, rd_en, carrier_tick, tx_done, rx_first_bits} = 6'h00;
      {low_freq_osc, sib0_underflow, sib1_underflow, addr, wr_data} = 19'h00000;
      r = $urandom(74811);
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      foreach (offs[i]) rdc(offs[i], 8'h00);
      wr(8'h19, 8'hff);
      rdc(8'h19, 8'hbb);
      m_rel = $urandom % 65536;
      wr(8'h1a, 8'(m_rel >> 8));
      wr(8'h1b, 8'(m_rel));
      wr(8'h19, 8'h08);
      pls(3, 1);
      st_chk;
      go(8'h08);
      st_chk;
      r = $urandom % 4 + 2;
      wr(8'h1a, 8'h00);
      wr(8'h1b, 8'(r));
      st_chk;
      m_rel = r;
      go(8'h08);
      wr(8'h32, 8'h01);
      pls(0, m_rel + 1);
      step(m_rel + 1);
      st_chk;
      check("irq", {7'h00, timer_irq}, 8'h01);
      wr(8'h31, 8'h01);
      wr(8'h32, 8'h00);
      pls(0, m_rel + 1);
      m_uf++;
      check("irq", {7'h00, timer_irq}, 8'h00);
      rdc(8'h30, 8'h05);
      go(8'h00);
      pls(0, m_rel + 3);
      step(m_rel + 3);
      st_chk;
      go(8'h09);
      pls(0, 4);
      step(1);
      st_chk;
      for (int w = 1; w < 3; w++) begin
         go(8'h09 + 8'(w));
         pls(w, 1);
         pls(3 - w, 1);
         pls(0, 1);
         step(1);
         st_chk;
      end
      wr(8'h19, 8'h90);
      wr(8'h33, 8'h02);
      pls(3, 1);
      m_run = 1;
      m_cnt = m_rel;
      st_chk;
      pls(4, 1);
      m_run = 0;
      st_chk;
      wr(8'h19, 8'h10);
      pls(3, 1);
      pls(4, 1);
      m_run = 1;
      st_chk;
      for (int s = 2; s < 4; s++) begin
         wr(8'h19, 8'h88 | 8'(s << 4));
         wr(8'h33, 8'h02);
         m_auto = 1;
         m_hold = (s == 2);
         osc_rise;
         m_run = 1;
         m_cnt = m_rel;
         pls(4, 1);
         pls(0, m_rel + 1);
         step(m_rel + 1);
         st_chk;
         osc_rise;
         m_run = 0;
         st_chk;
      end
      check("underflows", 8'(uf_seen), 8'(m_uf));
      final_report;
   end
endmodule : nct_timer_tb
